// *** logic/stdc_regs.svh ***
/*
 * Constants for the seek / tach gain diagnostic result coder: result codes,
 * parameter limits and timing counts.
 * Assumes a 25 MHz clock; times are converted to cycle counts here.
 */
`ifndef STDC_REGS_SVH
`define STDC_REGS_SVH

`define STDC_CODE_PARAM     8'h01
`define STDC_CODE_GAIN_LO   8'h01
`define STDC_CODE_GAIN_HI   8'h02
`define STDC_CODE_DIFF32    8'h10
`define STDC_CODE_DIFF0     8'h20
`define STDC_CODE_GAIN_LOW  8'h81
`define STDC_CODE_GAIN_HIGH 8'h82
`define STDC_CODE_ONLINE    8'hA1
`define STDC_CODE_READY     8'hA2
`define STDC_CODE_STILL_RDY 8'hA3
`define STDC_CODE_SEEK_INC  8'hA4
`define STDC_CODE_RDY_TMO   8'hA5
`define STDC_CODE_SEQ_TMO   8'hA6
`define STDC_CODE_PASS      8'hFF

`define STDC_CYL_HI_MAX     8'h03
// ready must be seen low this many cycles after a recal strobe or the alternate-seek seek strobe (not the tach seek)
`define STDC_DROP_CYC       32'h00000008

`define STDC_CLK_HZ         25000000
`define STDC_READY_MS       1000
`define STDC_SEQ_MS         30000
`define STDC_DIFF32_MS      278
`define STDC_DIFF0_MS       69
// times convert exactly; the longest fits in 32 bits
`define STDC_MS_CYC(ms)     ((ms) * (`STDC_CLK_HZ / 1000))

`endif

// *** logic/stdc_pkg.sv ***
/*
 * Types for the seek / tach gain diagnostic result coder.
 * Assumes nothing beyond the constants header.
 */
package stdc_pkg;
	typedef enum logic [1:0] {
		STDC_RT_ALT_SEEK = 2'h0,
		STDC_RT_INC_SEEK = 2'h1,
		STDC_RT_RND_SEEK = 2'h2,
		STDC_RT_TACH     = 2'h3
	} stdc_routine_t;

	typedef enum logic [10:0] {
		STDC_IDLE     = 11'h001,
		STDC_SEQ_UP   = 11'h002,
		STDC_PRECHK   = 11'h004,
		STDC_RECAL    = 11'h008,
		STDC_DROPCHK  = 11'h010,
		STDC_RDY_WAIT = 11'h020,
		STDC_SEEK     = 11'h040,
		STDC_DIFF32   = 11'h080,
		STDC_DIFF0    = 11'h100,
		STDC_GAIN     = 11'h200,
		STDC_DONE     = 11'h400
	} stdc_state_t;
endpackage

// *** logic/stdc_coder.sv ***
/*
 * Diagnostic result coder: runs a seek or tach gain routine against the
 * drive and produces one result byte.
 * Assumes drive status lines are asynchronous pins; the tach gain
 * comparison result is supplied by a measurement on the same clock.
 */
`include "stdc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module stdc_coder #(
	parameter int unsigned READY_CYC  = `STDC_MS_CYC(`STDC_READY_MS),
	parameter int unsigned SEQ_CYC    = `STDC_MS_CYC(`STDC_SEQ_MS),
	parameter int unsigned DIFF32_CYC = `STDC_MS_CYC(`STDC_DIFF32_MS),
	parameter int unsigned DIFF0_CYC  = `STDC_MS_CYC(`STDC_DIFF0_MS)
) (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          start,
	input  wire logic [1:0]    routine,
	input  wire logic [7:0]    cyl_hi_inner,
	input  wire logic [7:0]    cyl_lo_inner,
	input  wire logic [7:0]    cyl_hi_outer,
	input  wire logic [7:0]    cyl_lo_outer,
	input  wire logic          gain_below_nominal,
	input  wire logic          gain_above_nominal,
	input  wire logic          gain_below_limit,
	input  wire logic          gain_above_limit,
	input  wire logic          drive_online,
	input  wire logic          drive_ready,
	input  wire logic          seek_complete,
	input  wire logic          track_difference_under_32,
	input  wire logic          track_difference_zero,
	output logic               sequence_up,
	output logic               recal_strobe,
	output logic               seek_strobe,
	output logic               cylinder_address_value_hi,
	output logic [7:0]         cylinder_address_value,
	output logic               busy,
	output logic               done,
	output logic [7:0]         result_code
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int NPIN = 5;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
	assign pin_raw = {track_difference_zero, track_difference_under_32,
		seek_complete, drive_ready, drive_online};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					s1_q[gi]  <= 1'b0;
					s2_q[gi]  <= 1'b0;
					s3_q[gi]  <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					// change accepted only once stages two and three agree
					if (s2_q[gi] == s3_q[gi])
						pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	wire online_s = pin_q[0];
	wire ready_s  = pin_q[1];
	wire seekc_s  = pin_q[2];
	wire diff32_s = pin_q[3];
	wire diff0_s  = pin_q[4];

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	stdc_pkg::stdc_state_t   state_q, state_d;
	stdc_pkg::stdc_routine_t rt_q;
	logic [31:0] timer_q, timer_d;
	logic [7:0]  code_q, code_d;
	logic        fin_d;
	logic        done_q;
	logic        outer_q, outer_d;

	wire params_bad = (cyl_hi_inner > `STDC_CYL_HI_MAX)
		|| (cyl_hi_outer > `STDC_CYL_HI_MAX);
	wire is_tach = (rt_q == stdc_pkg::STDC_RT_TACH);
	wire is_alt  = (rt_q == stdc_pkg::STDC_RT_ALT_SEEK);
	wire tick_ok = (timer_q != 32'h0);

	always_comb begin
		state_d = state_q;
		timer_d = tick_ok ? timer_q - 32'h1 : timer_q;
		code_d  = code_q;
		outer_d = outer_q;
		fin_d   = 1'b0;
		case (state_q)
			stdc_pkg::STDC_IDLE: begin
				if (start) begin
					outer_d = 1'b0;
					if ((routine == 2'(stdc_pkg::STDC_RT_ALT_SEEK)) && params_bad) begin
						code_d  = `STDC_CODE_PARAM;
						state_d = stdc_pkg::STDC_DONE;
					end else begin
						timer_d = SEQ_CYC;
						state_d = stdc_pkg::STDC_SEQ_UP;
					end
				end
			end
			stdc_pkg::STDC_SEQ_UP: begin
				if (online_s && ready_s)
					state_d = stdc_pkg::STDC_PRECHK;
				else if (!tick_ok) begin
					code_d  = `STDC_CODE_SEQ_TMO;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_PRECHK: begin
				// first failure only; online takes priority over ready
				if (!online_s) begin
					code_d  = `STDC_CODE_ONLINE;
					state_d = stdc_pkg::STDC_DONE;
				end else if (!ready_s) begin
					code_d  = `STDC_CODE_READY;
					state_d = stdc_pkg::STDC_DONE;
				end else begin
					state_d = stdc_pkg::STDC_RECAL;
				end
			end
			stdc_pkg::STDC_RECAL: begin
				// allow the strobe to pass the drive and our synchroniser
				timer_d = `STDC_DROP_CYC;
				state_d = stdc_pkg::STDC_DROPCHK;
			end
			stdc_pkg::STDC_DROPCHK: begin
				if (!ready_s) begin
					timer_d = READY_CYC;
					state_d = stdc_pkg::STDC_RDY_WAIT;
				end else if (!tick_ok) begin
					code_d  = `STDC_CODE_STILL_RDY;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_RDY_WAIT: begin
				if (ready_s) begin
					if (!seekc_s) begin
						code_d  = `STDC_CODE_SEEK_INC;
						state_d = stdc_pkg::STDC_DONE;
					end else
						state_d = stdc_pkg::STDC_SEEK;
				end else if (!tick_ok) begin
					code_d  = `STDC_CODE_RDY_TMO;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_SEEK: begin
				if (is_tach) begin
					timer_d = DIFF32_CYC;
					state_d = stdc_pkg::STDC_DIFF32;
				end else if (is_alt && !outer_q) begin
					// second pass loads the outer cylinder address but issues no seek strobe
					outer_d = 1'b1;
					timer_d = `STDC_DROP_CYC;
					state_d = stdc_pkg::STDC_DROPCHK;
				end else begin
					code_d  = `STDC_CODE_PASS;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_DIFF32: begin
				if (diff32_s) begin
					timer_d = DIFF0_CYC;
					state_d = stdc_pkg::STDC_DIFF0;
				end else if (!tick_ok) begin
					code_d  = `STDC_CODE_DIFF32;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_DIFF0: begin
				if (diff0_s)
					state_d = stdc_pkg::STDC_GAIN;
				else if (!tick_ok) begin
					code_d  = `STDC_CODE_DIFF0;
					state_d = stdc_pkg::STDC_DONE;
				end
			end
			stdc_pkg::STDC_GAIN: begin
				if (gain_below_limit)
					code_d = `STDC_CODE_GAIN_LOW;
				else if (gain_above_limit)
					code_d = `STDC_CODE_GAIN_HIGH;
				else if (gain_below_nominal)
					code_d = `STDC_CODE_GAIN_LO;
				else if (gain_above_nominal)
					code_d = `STDC_CODE_GAIN_HI;
				else
					code_d = `STDC_CODE_PASS;
				state_d = stdc_pkg::STDC_DONE;
			end
			stdc_pkg::STDC_DONE: begin
				fin_d   = 1'b1;
				state_d = stdc_pkg::STDC_IDLE;
			end
			default: state_d = stdc_pkg::STDC_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= stdc_pkg::STDC_IDLE;
			timer_q <= 32'h0;
			code_q  <= 8'h00;
			outer_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			code_q  <= code_d;
			outer_q <= outer_d;
			done_q  <= fin_d;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			rt_q <= stdc_pkg::STDC_RT_ALT_SEEK;
		else if ((state_q == stdc_pkg::STDC_IDLE) && start)
			rt_q <= stdc_pkg::stdc_routine_t'(routine);
	end

	// ------------------------------------------------------------
	// drive commands
	// ------------------------------------------------------------
	logic [7:0] cav_q;
	logic       cav_hi_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cav_q    <= 8'h00;
			cav_hi_q <= 1'b0;
		end else if (state_q == stdc_pkg::STDC_RDY_WAIT) begin
			cav_q    <= outer_q ? cyl_lo_outer : cyl_lo_inner;
			cav_hi_q <= outer_q ? (cyl_hi_outer != 8'h00) : (cyl_hi_inner != 8'h00);
		end
	end

	assign sequence_up  = (state_q == stdc_pkg::STDC_SEQ_UP);
	assign recal_strobe = (state_q == stdc_pkg::STDC_RECAL);
	// tach routine times its difference lines from this seek
	assign seek_strobe  = (state_q == stdc_pkg::STDC_SEEK) && (is_tach || (is_alt && !outer_q));
	assign cylinder_address_value    = cav_q;
	assign cylinder_address_value_hi = cav_hi_q;
	assign busy        = (state_q != stdc_pkg::STDC_IDLE);
	assign done        = done_q;
	assign result_code = code_q;

endmodule

`default_nettype wire

// *** verification/stdc_coder_sva.sv ***
/*
 * Checker for the diagnostic result coder, bound to its ports.
 * Assumes the bind hands on the short wait parameters.
 */
`timescale 1ns/100ps
`default_nettype none
module stdc_coder_sva #(
	parameter int unsigned READY_CYC = 50,
	parameter int unsigned SEQ_CYC   = 100
) (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       start,
	input wire logic [1:0] routine,
	input wire logic [7:0] cyl_hi_inner,
	input wire logic       drive_ready,
	input wire logic       sequence_up,
	input wire logic       recal_strobe,
	input wire logic       seek_strobe,
	input wire logic       busy,
	input wire logic       done,
	input wire logic [7:0] result_code
);
	// ----
	// wait counters
	// ----
	int unsigned seq_q;
	int unsigned low_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			seq_q <= 0;
			low_q <= 0;
		end else begin
			seq_q <= sequence_up ? seq_q + 1 : 0;
			low_q <= (busy && !sequence_up && !drive_ready) ? low_q + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence recal_s; recal_strobe; endsequence
	sequence stuck_s; drive_ready [*8]; endsequence
	chk_param_fast: assert property (start && !busy && routine == 2'h0 && cyl_hi_inner > 8'h03
		|-> ##[1:3] done && result_code == 8'h01) else $error("bad byte not reported");
	chk_stuck_ready: assert property (recal_s ##1 stuck_s |-> ##[0:6] done && result_code == 8'hA3)
		else $error("stuck ready not reported");
	chk_spin_bound: assert property (seq_q <= SEQ_CYC + 8) else $error("spin-up wait too long");
	chk_ready_bound: assert property (low_q <= READY_CYC + 8) else $error("ready wait too long");
	chk_recal_after: assert property (recal_strobe |-> $past(busy) && !$past(sequence_up))
		else $error("recal without status check");
	chk_recal_pulse: assert property (recal_strobe |=> !recal_strobe) else $error("recal too long");
	chk_seek_pulse: assert property (seek_strobe |=> !seek_strobe) else $error("seek too long");
	chk_done_pulse: assert property (done |=> !done) else $error("second result");
	chk_done_idle: assert property (done |-> !busy) else $error("busy after result");
endmodule
bind stdc_coder stdc_coder_sva #(.READY_CYC(READY_CYC), .SEQ_CYC(SEQ_CYC)) u_stdc_coder_sva (.clock, .rst_b,
	.start, .routine, .cyl_hi_inner, .drive_ready, .sequence_up, .recal_strobe, .seek_strobe, .busy, .done,
	.result_code);
`default_nettype wire

// *** verification/stdc_drive_model.sv ***
/*
 * Behavioural drive: spin-up, ready drop on recal or seek, difference lines.
 * Assumes mode is held for a whole routine.
 */
`timescale 1ns/100ps
`default_nettype none
module stdc_drive_model (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       sequence_up,
	input  wire logic       recal_strobe,
	input  wire logic       seek_strobe,
	input  wire logic [2:0] mode,
	output logic            drive_online,
	output logic            drive_ready,
	output logic            seek_complete,
	output logic            track_difference_under_32,
	output logic            track_difference_zero
);
	// ----
	// mode 0 good, 1 no online, 2 no ready, 3 ready stuck, 4 no return,
	// 5 no seek complete, 6 no under 32, 7 no zero
	// ----
	logic [3:0] spin_q;
	logic [7:0] cnt_q;
	logic       moved_q;
	wire logic  up;
	assign up = spin_q >= 4'h5;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			spin_q <= 4'h0;
			cnt_q <= 8'hFF;
			moved_q <= 1'b0;
		end else begin
			if (sequence_up && spin_q != 4'hF)
				spin_q <= spin_q + 4'h1;
			if (recal_strobe || seek_strobe) begin
				cnt_q <= 8'h00;
				moved_q <= 1'b1;
			end else if (cnt_q != 8'hFF)
				cnt_q <= cnt_q + 8'h01;
		end
	end
	assign drive_online = up && mode != 3'h1;
	assign drive_ready = up && mode != 3'h2 && (mode == 3'h3 || (cnt_q >= 8'h0A && !(mode == 3'h4 && moved_q)));
	assign seek_complete = drive_ready && mode != 3'h5;
	assign track_difference_under_32 = moved_q && cnt_q >= 8'h05 && mode != 3'h6;
	assign track_difference_zero = moved_q && cnt_q >= 8'h0C && mode != 3'h7;
endmodule
`default_nettype wire

// *** verification/test_seek_tach_diag_result_coder.sv ***
/*
 * Self-checking bench for the result coder against the drive model.
 * Assumes short wait parameters and a 25 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
module test_seek_tach_diag_result_coder;
	logic        clock = 1'b0, rst_b = 1'b0, drv_rst_b = 1'b0, start = 1'b0;
	logic [1:0]  routine = 2'h0;
	logic [2:0]  mode = 3'h0;
	logic [7:0]  cyl_hi_inner = 8'h00, cyl_lo_inner = 8'h00, cyl_hi_outer = 8'h00, cyl_lo_outer = 8'h00;
	logic        gain_below_nominal = 1'b0, gain_above_nominal = 1'b0, gain_below_limit = 1'b0;
	logic        gain_above_limit = 1'b0;
	logic        drive_online, drive_ready, seek_complete, track_difference_under_32, track_difference_zero;
	logic        sequence_up, recal_strobe, seek_strobe, busy, done;
	logic        cylinder_address_value_hi;
	logic [7:0]  cylinder_address_value;
	logic [7:0]  result_code;
	logic [31:0] lfsr_state = 32'h924B;
	int          n_fail = 0, check_count = 0, cyc = 0;
	stdc_coder #(.READY_CYC(50), .SEQ_CYC(100), .DIFF32_CYC(50), .DIFF0_CYC(50)) u_stdc_coder (.clock, .rst_b,
		.start, .routine, .cyl_hi_inner, .cyl_lo_inner, .cyl_hi_outer, .cyl_lo_outer, .gain_below_nominal,
		.gain_above_nominal, .gain_below_limit, .gain_above_limit, .drive_online, .drive_ready, .seek_complete,
		.track_difference_under_32, .track_difference_zero, .sequence_up, .recal_strobe, .seek_strobe,
		.cylinder_address_value_hi, .cylinder_address_value, .busy, .done, .result_code);
	stdc_drive_model u_stdc_drive_model (.clock, .rst_b(drv_rst_b), .sequence_up, .recal_strobe, .seek_strobe,
		.mode, .drive_online, .drive_ready, .seek_complete, .track_difference_under_32, .track_difference_zero);
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			give_verdict();
		end
	end
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// limit checks win over nominal ones; first failure only
	function automatic logic [7:0] expect_code(logic [1:0] rt, logic [2:0] md, logic [7:0] hi, logic [7:0] ho,
		logic [3:0] g);
		if (rt == 2'h0 && (hi > 8'h03 || ho > 8'h03)) return 8'h01;
		if (md == 3'h1 || md == 3'h2) return 8'hA6;
		if (md == 3'h3) return 8'hA3;
		if (md == 3'h4) return 8'hA5;
		if (md == 3'h5) return 8'hA4;
		if (rt != 2'h3) return 8'hFF;
		if (md == 3'h6) return 8'h10;
		if (md == 3'h7) return 8'h20;
		if (g[0]) return 8'h81;
		if (g[1]) return 8'h82;
		if (g[2]) return 8'h01;
		if (g[3]) return 8'h02;
		return 8'hFF;
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic run(logic [1:0] rt, logic [2:0] md, logic [7:0] hi, logic [7:0] ho, logic [3:0] g);
		int k;
		logic [7:0] want;
		@(negedge clock);
		drv_rst_b = 1'b0;
		lfsr_state = lfsr_next(lfsr_state);
		{cyl_lo_inner, cyl_lo_outer} = lfsr_state[15:0];
		{routine, mode, cyl_hi_inner, cyl_hi_outer} = {rt, md, hi, ho};
		{gain_above_nominal, gain_below_nominal, gain_above_limit, gain_below_limit} = g;
		// let the coder's synchronisers see the drive go down before start
		repeat (6) @(negedge clock);
		drv_rst_b = 1'b1;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 2000) begin
			@(posedge clock);
			#1;
			k++;
		end
		want = expect_code(rt, md, hi, ho, g);
		`CHK("done", 1'b1, done)
		`CHK("result_code", want, result_code)
		if (want == 8'hFF) begin
			`CHK("cylinder_address_value", (rt == 2'h0) ? cyl_lo_outer : cyl_lo_inner, cylinder_address_value)
			`CHK("cylinder_address_value_hi", |((rt == 2'h0) ? ho : hi), cylinder_address_value_hi)
		end
		$display("test routine %0d mode %0d code %h", rt, md, result_code);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		rst_b = 1'b1;
		for (int m = 0; m < 8; m++) run(2'h3, m[2:0], 8'h00, 8'h00, 4'h0);
		for (int i = 0; i < 4; i++) run(2'h3, 3'h0, 8'h00, 8'h00, 4'h1 << i);
		run(2'h0, 3'h0, 8'h03, 8'h03, 4'h0);
		run(2'h0, 3'h5, 8'h00, 8'h04, 4'h0);
		run(2'h3, 3'h7, 8'h00, 8'h00, 4'hF);
		repeat (24) begin
			lfsr_state = lfsr_next(lfsr_state);
			run(lfsr_state[1:0], lfsr_state[4:2], {5'h00, lfsr_state[7:5]}, {5'h00, lfsr_state[10:8]},
				lfsr_state[14:11]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
